// >>> logic/wwdt_pkg.sv
// Package: register map, field layout, codes, timing and state types of the watchdog
package wwdt_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [1:0] WWDT_ADDR_CTRL = 2'h0;
  localparam logic [1:0] WWDT_ADDR_CODE = 2'h1;
  localparam logic [1:0] WWDT_ADDR_CNT = 2'h2;
  localparam logic [1:0] WWDT_ADDR_STAT = 2'h3;

  // ********************************************************************
  // Control fields and reset values
  // ********************************************************************
  localparam int WWDT_CTRL_EN_BIT = 5;
  localparam int WWDT_CTRL_WIN_LSB = 3;
  localparam int WWDT_CTRL_PER_LSB = 1;
  localparam int WWDT_CTRL_OUT_BIT = 0;
  localparam logic [7:0] WWDT_CTRL_RST = 8'h20;
  localparam logic [7:0] WWDT_STAT_FIXED = 8'h58;
  localparam int WWDT_STAT_OVF_BIT = 2;
  localparam int WWDT_STAT_WIN_BIT = 1;
  localparam int WWDT_STAT_RUN_BIT = 0;

  // ********************************************************************
  // Control codes and window thresholds
  // ********************************************************************
  localparam logic [7:0] WWDT_CODE_CLEAR = 8'h4E;
  localparam logic [7:0] WWDT_CODE_DISABLE = 8'hB1;
  localparam logic [7:0] WWDT_CNT_MAX = 8'hFF;
  localparam logic [7:0] WWDT_WIN_THR1 = 8'h40;
  localparam logic [7:0] WWDT_WIN_THR2 = 8'h80;
  localparam logic [7:0] WWDT_WIN_THR3 = 8'hC0;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int WWDT_CLK_MHZ = 20;
  localparam int WWDT_WARMUP_US = 100;
  localparam int WWDT_WARMUP_CYC = WWDT_WARMUP_US * WWDT_CLK_MHZ;
  localparam logic [11:0] WWDT_WARMUP_LAST = 12'(WWDT_WARMUP_CYC - 1);
  localparam int WWDT_PRESC_BASE_LOG2 = 4;

  // ********************************************************************
  // State types
  // ********************************************************************
  typedef enum logic [1:0] {
    WWDT_IDLE = 2'b01,
    WWDT_WARM = 2'b10
  } wwdt_warm_state_t;

  typedef struct packed {
    wwdt_warm_state_t st;
    logic [11:0] cnt;
    logic busy;
    logic done;
  } wwdt_warm_t;

  typedef struct packed {
    logic [15:0] div;
    logic tick;
  } wwdt_presc_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic run;
    logic [7:0] cnt;
    logic ovf_flag;
    logic win_flag;
    logic [7:0] rdata;
    logic nmi;
    logic rst_req;
  } wwdt_core_t;

endpackage

// >>> logic/wwdt_link_if.sv
// Interface: signals shared by the watchdog core, prescaler and warm-up sequencer
`timescale 1ns/10ps
interface wwdt_link_if;
  logic run;
  logic pause;
  logic [1:0] period_sel;
  logic tick;
  logic warm_start;
  logic warm_busy;
  logic warm_done;

  modport core (output run, output pause, output period_sel, input tick,
                output warm_start, input warm_busy, input warm_done);
  modport presc (input run, input pause, input period_sel, output tick);
  modport warm (input warm_start, output warm_busy, output warm_done);
endinterface

// >>> logic/wwdt_presc.sv
// Prescaler that makes the counter's source clock enable from the system clock
`timescale 1ns/10ps
module wwdt_presc
  import wwdt_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  wwdt_link_if.presc lnk
);
  wwdt_presc_t s_q, s_d;
  logic [15:0] mask;

  always_comb begin
    // Each step of the period select stretches the period by four
    mask = (16'h0001 << (WWDT_PRESC_BASE_LOG2 + 2 * int'(lnk.period_sel))) - 16'h0001;
    s_d = s_q;
    s_d.tick = 1'b0;
    if (lnk.run && !lnk.pause) begin
      s_d.div = s_q.div + 16'h0001;
      s_d.tick = ((s_q.div & mask) == mask);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.tick = s_q.tick;
endmodule

// >>> logic/wwdt_warm.sv
// Warm-up sequencer that holds the chip reset request until the warm-up time elapses
`timescale 1ns/10ps
module wwdt_warm
  import wwdt_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  wwdt_link_if.warm lnk
);
  wwdt_warm_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      WWDT_IDLE: begin
        if (lnk.warm_start) begin
          s_d.st = WWDT_WARM;
          s_d.cnt = '0;
          s_d.busy = 1'b1;
        end
      end
      WWDT_WARM: begin
        if (s_q.cnt == WWDT_WARMUP_LAST) begin
          s_d.st = WWDT_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 12'h001;
        end
      end
      default: begin
        s_d.st = WWDT_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  // Power-up also runs the warm-up before the watchdog starts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: WWDT_WARM, cnt: 12'h000, busy: 1'b1, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.warm_busy = s_q.busy;
  assign lnk.warm_done = s_q.done;
endmodule

// >>> logic/wwdt_top.sv
// Windowed watchdog timer: register port, 8-bit up counter, window check and actions
//
// Overview of operation
// - With the overflow action bit at 1, a counter overflow raises a chip reset request.
// - A reset request resets the chip and is held through the warm-up before release.
// - Writing the clear code zeroes the counter, which then keeps counting.
// - Writing the disable code stops the watchdog only while the enable bit is 0.
// - A clear write in the same cycle as an overflow clears and suppresses the overflow.
// - The counter readback register returns the live counter value.
// - The run state flag reads 1 while enabled and 0 while disabled.
// - An overflow interrupt sets the overflow interrupt flag.
// - A clear outside the allowed window sets the window violation flag.
// - Reading the status register clears both cause flags.
// - A cause flag set in the same cycle as a status read stays set.
// - With a window selected, an early clear raises an interrupt and does not clear.
// - With the action bit at 0, overflow raises a non-maskable interrupt and counting goes on.
// - Disabling zeroes the counter; enable is 1 after warm-up; setting enable restarts it.
// - The counter pauses in stop, idle and sleep modes and resumes afterwards.
`timescale 1ns/10ps
module wwdt_top
  import wwdt_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic low_power_pause,
  output logic nmi_req,
  output logic chip_rst_req
);

  // ********************************************************************
  // Submodules
  // ********************************************************************
  wwdt_link_if lnk ();

  wwdt_presc u_presc (
    .clk(clk),
    .arst_n(arst_n),
    .lnk(lnk.presc)
  );

  wwdt_warm u_warm (
    .clk(clk),
    .arst_n(arst_n),
    .lnk(lnk.warm)
  );

  // ********************************************************************
  // State
  // ********************************************************************
  localparam wwdt_core_t CORE_RST = '{
    ctrl: WWDT_CTRL_RST, run: 1'b0, cnt: 8'h00, ovf_flag: 1'b0, win_flag: 1'b0,
    rdata: 8'h00, nmi: 1'b0, rst_req: 1'b1
  };

  wwdt_core_t s_q, s_d;
  logic wr_ctrl, wr_code, rd_stat;
  logic [1:0] win_sel;
  logic [7:0] win_thr;
  logic clr_ok, ovf, clear_hit, disable_hit, ovf_event, win_event;
  logic [7:0] stat_val;

  // ********************************************************************
  // Decode
  // ********************************************************************
  always_comb begin
    wr_ctrl = wr_en && (addr == WWDT_ADDR_CTRL);
    wr_code = wr_en && (addr == WWDT_ADDR_CODE);
    rd_stat = rd_en && (addr == WWDT_ADDR_STAT);
    win_sel = s_q.ctrl[WWDT_CTRL_WIN_LSB +: 2];
    case (win_sel)
      2'b01: win_thr = WWDT_WIN_THR1;
      2'b10: win_thr = WWDT_WIN_THR2;
      2'b11: win_thr = WWDT_WIN_THR3;
      default: win_thr = 8'h00;
    endcase
    // Window 00 accepts a clear at any count
    clr_ok = (win_sel == 2'b00) || (s_q.cnt >= win_thr);
    ovf = s_q.run && lnk.tick && (s_q.cnt == WWDT_CNT_MAX);
    clear_hit = wr_code && (wdata == WWDT_CODE_CLEAR) && s_q.run && clr_ok;
    win_event = wr_code && (wdata == WWDT_CODE_CLEAR) && s_q.run && !clr_ok;
    disable_hit = wr_code && (wdata == WWDT_CODE_DISABLE)
                  && !s_q.ctrl[WWDT_CTRL_EN_BIT];
    // Clearing or disabling in the overflow cycle takes priority
    ovf_event = ovf && !clear_hit && !disable_hit;
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    s_d = s_q;
    s_d.nmi = 1'b0;
    stat_val = WWDT_STAT_FIXED;
    stat_val[WWDT_STAT_OVF_BIT] = s_q.ovf_flag;
    stat_val[WWDT_STAT_WIN_BIT] = s_q.win_flag;
    stat_val[WWDT_STAT_RUN_BIT] = s_q.run;
    lnk.warm_start = 1'b0;

    if (lnk.warm_busy || lnk.warm_done) begin
      // Held at reset values for as long as the reset request still shows
      s_d = CORE_RST;
      if (lnk.warm_done) begin
        s_d.run = s_q.ctrl[WWDT_CTRL_EN_BIT];
      end
    end else begin
      if (s_q.run && lnk.tick) begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
      if (wr_ctrl) begin
        s_d.ctrl = wdata;
        if (wdata[WWDT_CTRL_EN_BIT]) begin
          s_d.run = 1'b1;
        end
      end
      if (clear_hit) begin
        s_d.cnt = 8'h00;
      end
      if (disable_hit) begin
        s_d.run = 1'b0;
        s_d.cnt = 8'h00;
      end
      if (rd_stat) begin
        s_d.ovf_flag = 1'b0;
        s_d.win_flag = 1'b0;
      end
      if (ovf_event) begin
        if (s_q.ctrl[WWDT_CTRL_OUT_BIT]) begin
          lnk.warm_start = 1'b1;
        end else begin
          s_d.nmi = 1'b1;
          s_d.ovf_flag = 1'b1;
        end
      end
      if (win_event) begin
        s_d.nmi = 1'b1;
        s_d.win_flag = 1'b1;
      end
      // Read data of the cycle after the strobe only
      s_d.rdata = 8'h00;
      if (rd_en) begin
        case (addr)
          WWDT_ADDR_CTRL: s_d.rdata = s_q.ctrl;
          WWDT_ADDR_CNT: s_d.rdata = s_q.cnt;
          WWDT_ADDR_STAT: s_d.rdata = stat_val;
          default: s_d.rdata = 8'h00;
        endcase
      end
    end
    // Request stands from the overflow until the warm-up ends
    s_d.rst_req = lnk.warm_start || (lnk.warm_busy && !lnk.warm_done);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************************
  // Outputs and shared signals
  // ********************************************************************
  always_comb begin
    lnk.run = s_q.run;
    // A low-power pause also freezes the prescaler; a tick registered before it still counts once
    lnk.pause = low_power_pause;
    lnk.period_sel = s_q.ctrl[WWDT_CTRL_PER_LSB +: 2];
  end

  assign rdata = s_q.rdata;
  assign nmi_req = s_q.nmi;
  assign chip_rst_req = s_q.rst_req;
endmodule

// >>> test/wwdt_checker.sv
// Port-level assertions of the windowed watchdog
`timescale 1ns/10ps
module wwdt_checker
  import wwdt_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic low_power_pause,
  input wire logic nmi_req,
  input wire logic chip_rst_req
);
  // ****************
  // Helpers and assertions
  // ****************
  logic [11:0] hi_q;
  logic stat_rd;
  logic cnt_rd;
  logic clr_wr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  assign stat_rd = rd_en && addr == WWDT_ADDR_STAT && !chip_rst_req;
  assign cnt_rd = rd_en && addr == WWDT_ADDR_CNT && !chip_rst_req;
  assign clr_wr = wr_en && addr == WWDT_ADDR_CODE && wdata == WWDT_CODE_CLEAR && !chip_rst_req;
  // Saturates so that a stuck reset request cannot wrap back to a small count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_q <= 12'h000;
    end else if (!chip_rst_req) begin
      hi_q <= 12'h000;
    end else if (hi_q != 12'hFFF) begin
      hi_q <= hi_q + 12'h001;
    end
  end
  sequence s_two_stat;
    stat_rd ##1 (stat_rd && !nmi_req);
  endsequence
  sequence s_clr_cnt;
    clr_wr ##1 (cnt_rd && !nmi_req);
  endsequence
  rdata_idle_a: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data not zero after idle cycle");
  rst_quiet_a: assert property (chip_rst_req && rd_en |=> rdata == 8'h00)
    else $error("read answered during reset");
  stat_fixed_a: assert property (stat_rd |=> rdata[7:3] == WWDT_STAT_FIXED[7:3])
    else $error("status fixed bits wrong");
  stat_clear_a: assert property (s_two_stat |=> rdata[2:1] == 2'b00)
    else $error("cause flags survived a status read");
  clear_zero_a: assert property (s_clr_cnt |=> rdata == 8'h00)
    else $error("clear code did not zero the counter");
  cnt_step_a: assert property (cnt_rd ##1 cnt_rd |=> rdata - $past(rdata) <= 8'h01)
    else $error("counter moved by more than one");
  cnt_pause_a: assert property (low_power_pause ##1 (cnt_rd && low_power_pause)[*2] |=>
    $stable(rdata)) else $error("counter moved while paused");
  warm_len_a: assert property ($fell(chip_rst_req) |-> hi_q >= WWDT_WARMUP_LAST)
    else $error("reset request released before warm-up end");
endmodule

bind wwdt_top wwdt_checker chk_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .low_power_pause(low_power_pause),
  .nmi_req(nmi_req), .chip_rst_req(chip_rst_req));

// >>> test/tb_top.sv
// Self-checking bench of the windowed watchdog
`timescale 1ns/10ps
module tb_top
  import wwdt_pkg::*;
;
  // ****************
  // Stimulus and checks
  // ****************
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic low_power_pause = 1'b0;
  logic [7:0] rdata;
  logic nmi_req;
  logic chip_rst_req;
  logic [7:0] v1;
  logic [7:0] v2;
  logic [7:0] base;
  logic [7:0] nmis = 8'h00;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Rows: write flag, address, then write data or expected read data
  logic [10:0] rows [9] = '{11'h020, 11'h359, 11'h100, 11'h400, 11'h5B1, 11'h358, 11'h200,
    11'h420, 11'h359};
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (nmi_req === 1'b1) nmis <= nmis + 8'h01;
    if (cycles == 30000) begin
      mismatches++;
      final_report();
    end
  end
  wwdt_top uut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .low_power_pause(low_power_pause), .nmi_req(nmi_req),
    .chip_rst_req(chip_rst_req));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Optional clear write right before the read, so both land on adjacent edges
  task automatic rd(input logic [1:0] a, input int n, input bit clr);
    @(posedge clk);
    if (clr) begin
      addr <= WWDT_ADDR_CODE;
      wdata <= WWDT_CODE_CLEAR;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
    end
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    if (n == 1) rd_en <= 1'b0;
    #1 v1 = rdata;
    if (n == 2) begin
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v2 = rdata;
    end
  endtask
  task automatic wait_low();
    for (int i = 0; i < 3000 && chip_rst_req !== 1'b0; i++) begin
      @(posedge clk);
    end
    chk({7'h00, chip_rst_req}, 8'h00);
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    chk({7'h00, chip_rst_req}, 8'h01);
    arst_n <= 1'b1;
    rd(WWDT_ADDR_CTRL, 1, 1'b0);
    chk(v1, 8'h00);
    wait_low();
    foreach (rows[i]) begin
      if (rows[i][10]) wr(rows[i][9:8], rows[i][7:0]);
      else begin
        rd(rows[i][9:8], 1, 1'b0);
        chk(v1, rows[i][7:0]);
      end
    end
    rd(WWDT_ADDR_CNT, 1, 1'b1);
    chk(v1, 8'h00);
    @(posedge clk) low_power_pause <= 1'b1;
    rd(WWDT_ADDR_CNT, 1, 1'b0);
    base = v1;
    repeat (40) @(posedge clk);
    rd(WWDT_ADDR_CNT, 2, 1'b0);
    chk(v1, base);
    chk(v2, base);
    @(posedge clk) low_power_pause <= 1'b0;
    repeat (160) @(posedge clk);
    rd(WWDT_ADDR_CNT, 2, 1'b0);
    chk({7'h00, v1 >= 8'h09 && v1 <= 8'h0D}, 8'h01);
    wr(WWDT_ADDR_CODE, WWDT_CODE_DISABLE);
    rd(WWDT_ADDR_STAT, 1, 1'b0);
    chk(v1, 8'h59);
    // Early clear with window 01: refused, flagged, counter kept
    wr(WWDT_ADDR_CTRL, 8'h28);
    base = nmis;
    rd(WWDT_ADDR_CNT, 1, 1'b1);
    chk({7'h00, v1 != 8'h00}, 8'h01);
    rd(WWDT_ADDR_STAT, 2, 1'b0);
    chk(v1, 8'h5B);
    chk(v2, 8'h59);
    chk(nmis, base + 8'h01);
    repeat (1100) @(posedge clk);
    rd(WWDT_ADDR_CNT, 1, 1'b1);
    chk(v1, 8'h00);
    chk(nmis, base + 8'h01);
    wr(WWDT_ADDR_CTRL, 8'h20);
    rd(WWDT_ADDR_CNT, 1, 1'b1);
    repeat (4150) @(posedge clk);
    rd(WWDT_ADDR_STAT, 1, 1'b0);
    chk(v1, 8'h5D);
    chk(nmis, base + 8'h02);
    wr(WWDT_ADDR_CTRL, 8'h21);
    for (int i = 0; i < 4200 && chip_rst_req !== 1'b1; i++) begin
      @(posedge clk);
    end
    chk({7'h00, chip_rst_req}, 8'h01);
    wait_low();
    rd(WWDT_ADDR_CTRL, 1, 1'b0);
    chk(v1, 8'h20);
    final_report();
  end
endmodule
